// *** rtl/pld_top.sv ***
// indicator drivers, hardware reset pin and power-down / interrupt pin
// assumes status inputs come from logic on the same clock; pins are asynchronous
//
// Contract
// - in mode 1 the link indicator is on exactly while the link is good.
// - in modes 2 and 3 the link indicator is on with link good and blinks on activity.
// - the speed indicator is on at 100 Mb/s and off at 10 Mb/s.
// - in mode 1 the activity indicator pulses on for transmit or receive activity.
// - in mode 3 the activity indicator can be set to show full duplex instead.
// - the test reset input is active low and clears asynchronously.
// - the reset pin held low for at least 1 us resets every register except the avalon port, pin synchronisers, low counter and internal_reset (nrst only).
// - a hardware reset also samples the straps again and reapplies them.
// - the dual pin is a power-down input after reset until software selects interrupt.
// - in power-down function a low level on the pin puts the device in power-down.
// - in interrupt function the pin is pulled low open-drain on an interrupt condition.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module pld_top #(
  parameter int TICK_CYCLES = pld_pkg::TICK_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic irq_cond,
  input wire logic [pld_pkg::STRAP_W-1:0] strap_pins,
  input wire logic hw_reset_n,
  input wire logic test_reset_n,
  input wire logic powerdown_or_irq_pin_i,
  output logic powerdown_or_irq_pin_o,
  output logic powerdown_or_irq_pin_oe,
  output logic link_indicator,
  output logic speed_indicator,
  output logic activity_indicator,
  output logic powerdown,
  output logic internal_reset
);
  import pld_pkg::*;

  localparam logic [CNT_W-1:0] RST_MIN = CNT_W'(HW_RESET_MIN_CYC);
  localparam logic [CNT_W-1:0] BLINK_LOAD = CNT_W'(BLINK_TICKS - 1);

  logic hw_pin_lvl;
  logic pd_pin_lvl;
  logic [CNT_W-1:0] low_cnt_q;
  logic hw_rst_q;
  logic hw_rst_dly_q;
  logic rst;
  logic strap_load_q;
  logic [STRAP_W-1:0] strap_q;
  logic [4:0] ctrl_q;
  logic test_mode_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic act_held;
  logic [CNT_W-1:0] blink_cnt_q;
  logic blink_q;
  logic ack_q;
  logic [31:0] status_w;
  logic ctrl_wr;
  logic [31:0] quiet_cnt_q;
  pld_mode_t mode;

  assign rst = !nrst || hw_rst_q;
  assign mode = pld_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign ctrl_wr = avs_write && ack_q && avs_address == CTRL_OFS && avs_byteenable[0];

  pld_sync3 #(.RST_VAL(1'b1)) u_hw_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(hw_reset_n),
    .level(hw_pin_lvl)
  );

  pld_sync3 #(.RST_VAL(1'b1)) u_pd_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(powerdown_or_irq_pin_i),
    .level(pd_pin_lvl)
  );

  // shorter glitches on the reset pin are ignored
  always_ff @(posedge clock) begin
    if (!nrst) begin
      low_cnt_q <= '0;
      hw_rst_q <= 1'b0;
    end else if (hw_pin_lvl) begin
      low_cnt_q <= '0;
      hw_rst_q <= 1'b0;
    end else if (low_cnt_q != RST_MIN) begin
      low_cnt_q <= low_cnt_q + CNT_W'(1);
    end else begin
      hw_rst_q <= 1'b1;
    end
  end

  // straps are taken on the second cycle out of any reset
  always_ff @(posedge clock) begin
    hw_rst_dly_q <= rst;
    strap_load_q <= hw_rst_dly_q && !rst;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      strap_q <= '0;
    end else if (strap_load_q) begin
      strap_q <= strap_pins;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (strap_load_q) begin
      ctrl_q[CTRL_MODE_LSB +: 2] <= strap_pins[STRAP_LEDCFG_BIT] ? PLD_MODE_3 : PLD_MODE_1;
    end else if (ctrl_wr) begin
      ctrl_q <= avs_writedata[4:0];
    end
  end

  // test state clears without a clock edge
  // set only by a write, so a test reset stays in force until software sets it again
  always_ff @(posedge clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      test_mode_q <= 1'b0;
    end else if (rst) begin
      test_mode_q <= 1'b0;
    end else if (ctrl_wr) begin
      test_mode_q <= avs_writedata[CTRL_TEST_BIT];
    end
  end

  // slow tick for visible timing
  always_ff @(posedge clock) begin
    if (rst || tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
    end
  end

  pld_stretch #(.TICKS(STRETCH_TICKS)) u_act (
    .clock(clock),
    .rst(rst),
    .tick(tick_q),
    .event_in(tx_active || rx_active),
    .held(act_held)
  );

  // blink phase runs only while activity is held
  // opens with the off phase, so one short frame still shows
  always_ff @(posedge clock) begin
    if (rst || !act_held) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b1;
    end else if (tick_q) begin
      if (blink_cnt_q == BLINK_LOAD) begin
        blink_cnt_q <= '0;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      link_indicator <= 1'b0;
      speed_indicator <= 1'b0;
      activity_indicator <= 1'b0;
    end else begin
      speed_indicator <= speed_100;
      unique case (mode)
        PLD_MODE_2, PLD_MODE_3: begin
          link_indicator <= link_good && !(act_held && blink_q);
        end
        default: begin
          link_indicator <= link_good;
        end
      endcase
      if (mode == PLD_MODE_3 && ctrl_q[CTRL_DUPLEX_BIT]) begin
        activity_indicator <= full_duplex;
      end else begin
        activity_indicator <= act_held;
      end
    end
  end

  // dual pin; drive value is always low, only the enable moves
  always_ff @(posedge clock) begin
    if (rst) begin
      powerdown_or_irq_pin_o <= 1'b0;
      powerdown_or_irq_pin_oe <= 1'b0;
      powerdown <= 1'b0;
    end else begin
      powerdown_or_irq_pin_o <= 1'b0;
      powerdown_or_irq_pin_oe <= ctrl_q[CTRL_IRQSEL_BIT] && irq_cond;
      powerdown <= !ctrl_q[CTRL_IRQSEL_BIT] && !pd_pin_lvl;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= hw_rst_q;
    end
  end

  // avalon slave: one wait cycle, then the answer
  always_comb begin
    status_w = '0;
    status_w[ST_LINK_BIT] = link_good;
    status_w[ST_SPEED_BIT] = speed_100;
    status_w[ST_DUPLEX_BIT] = full_duplex;
    status_w[ST_PDOWN_BIT] = powerdown;
    status_w[ST_ACT_BIT] = act_held;
    status_w[ST_TEST_BIT] = test_mode_q;
    status_w[ST_STRAP_LSB +: STRAP_W] = strap_q;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          CTRL_OFS: avs_readdata <= {27'h0, ctrl_q};
          STATUS_OFS: avs_readdata <= status_w;
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  // cycles since the last activity event, only for the hold check
  always_ff @(posedge clock) begin
    if (rst || tx_active || rx_active) begin
      quiet_cnt_q <= '0;
    end else if (quiet_cnt_q != '1) begin
      quiet_cnt_q <= quiet_cnt_q + 32'h1;
    end
  end

  // checks
  a_link_mode_one: assert property (@(posedge clock) disable iff (rst)
    (mode == PLD_MODE_1 && $stable(mode)) |=> link_indicator == $past(link_good))
    else $error("link indicator does not follow link in mode 1");

  a_link_off_down: assert property (@(posedge clock) disable iff (rst)
    (!link_good) |=> !link_indicator)
    else $error("link indicator on without link");

  a_speed_follow: assert property (@(posedge clock) disable iff (rst)
    ##1 speed_indicator == $past(speed_100))
    else $error("speed indicator wrong");

  a_act_pulse: assert property (@(posedge clock) disable iff (rst)
    ((tx_active || rx_active) && mode == PLD_MODE_1) ##1 (mode == PLD_MODE_1)
    |=> activity_indicator)
    else $error("activity pulse missing");

  a_duplex_show: assert property (@(posedge clock) disable iff (rst)
    (mode == PLD_MODE_3 && ctrl_q[CTRL_DUPLEX_BIT]) |=> activity_indicator == $past(full_duplex))
    else $error("duplex status not shown");

  a_hw_reset_min: assert property (@(posedge clock) disable iff (!nrst)
    $rose(hw_rst_q) |-> $past(!hw_pin_lvl, 50))
    else $error("hardware reset taken too early");

  a_strap_reload: assert property (@(posedge clock) disable iff (rst)
    strap_load_q |=> strap_q == $past(strap_pins))
    else $error("straps not sampled");

  a_pin_default: assert property (@(posedge clock) disable iff (!nrst)
    $fell(rst) |-> !powerdown_or_irq_pin_oe && !ctrl_q[CTRL_IRQSEL_BIT])
    else $error("dual pin not powerdown after reset");

  a_pdown_enter: assert property (@(posedge clock) disable iff (rst)
    (!ctrl_q[CTRL_IRQSEL_BIT] && !pd_pin_lvl) |=> powerdown)
    else $error("powerdown not entered");

  a_irq_drive: assert property (@(posedge clock) disable iff (rst)
    (ctrl_q[CTRL_IRQSEL_BIT] && irq_cond) |=> powerdown_or_irq_pin_oe && !powerdown_or_irq_pin_o)
    else $error("interrupt not driven low");

  a_irq_release: assert property (@(posedge clock) disable iff (rst)
    (!irq_cond) |=> !powerdown_or_irq_pin_oe)
    else $error("pin driven with no interrupt");

  a_act_hold: assert property (@(posedge clock) disable iff (rst)
    $fell(act_held) |-> quiet_cnt_q > 32'((STRETCH_TICKS - 1) * TICK_CYCLES))
    else $error("activity hold ended too soon");

  a_test_clear: assert property (@(posedge clock) disable iff (!nrst)
    !test_reset_n |-> !test_mode_q)
    else $error("test state not cleared by test reset");
endmodule : pld_top

// *** rtl/pld_pkg.sv ***
// constants for the indicator, reset and power-down pin block
// assumes a single 50 MHz clock and a 32-bit avalon-mm register port
package pld_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int HW_RESET_MIN_NS = 1000;
  // least time rounds up
  localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int STRETCH_TICKS = 50;
  localparam int BLINK_TICKS = 50;
  localparam int CNT_W = 8;

  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUPLEX_BIT = 2;
  localparam int CTRL_IRQSEL_BIT = 3;
  localparam int CTRL_TEST_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;

  // status fields
  localparam int ST_LINK_BIT = 0;
  localparam int ST_SPEED_BIT = 1;
  localparam int ST_DUPLEX_BIT = 2;
  localparam int ST_PDOWN_BIT = 3;
  localparam int ST_ACT_BIT = 4;
  localparam int ST_TEST_BIT = 5;
  localparam int ST_STRAP_LSB = 8;

  localparam int STRAP_W = 4;
  localparam int STRAP_LEDCFG_BIT = 0;

  typedef enum logic [1:0] {
    PLD_MODE_1A = 2'h0,
    PLD_MODE_1 = 2'h1,
    PLD_MODE_2 = 2'h2,
    PLD_MODE_3 = 2'h3
  } pld_mode_t;
endpackage : pld_pkg

// *** rtl/pld_sync3.sv ***
// three-stage synchroniser for a pin level
// the output changes only once the second and third stages agree
`timescale 1ns/1ps
module pld_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      level <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule : pld_sync3

// *** rtl/pld_stretch.sv ***
// holds an output for a number of slow ticks after the last event
// assumes tick is a one-cycle enable pulse on the same clock
`timescale 1ns/1ps
module pld_stretch #(
  parameter int TICKS = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic event_in,
  output logic held
);
  import pld_pkg::*;
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(TICKS);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (event_in) begin
      cnt_q <= LOAD;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  assign held = (cnt_q != '0);
endmodule : pld_stretch

// *** testbench/pld_far_model.sv ***
// far side: pull-up on the dual pin, external pull-down, reset source
// assumes the bench pulses rst_go for one cycle with rst_cycles set
`timescale 1ns/1ps
module pld_far_model (
  input wire logic clock,
  input wire logic pin_oe,
  input wire logic pin_o,
  input wire logic pull_low,
  input wire logic rst_go,
  input wire logic [7:0] rst_cycles,
  output logic pin_level,
  output logic hw_reset_n
);
  logic [7:0] cnt_q = 8'h00;
  // weak pull-up unless someone drives low
  assign pin_level = (pin_oe ? pin_o : 1'b1) & !pull_low;
  always @(posedge clock) begin
    if (rst_go) begin
      cnt_q <= rst_cycles;
      hw_reset_n <= 1'b0;
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      cnt_q <= 8'h00;
      hw_reset_n <= 1'b1;
    end
  end
endmodule : pld_far_model

// *** testbench/phy_led_reset_powerdown_pins_tb.sv ***
// self-checking bench for pld_top
// assumes 50 MHz clock, tick shortened to 4 cycles
`timescale 1ns/1ps
module phy_led_reset_powerdown_pins_tb;
  import pld_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, strap_pins = 4'h6;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, link_good = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0;
  logic tx_active = 1'b0, rx_active = 1'b0, irq_cond = 1'b0, test_reset_n = 1'b1;
  logic pull_low = 1'b0, rst_go = 1'b0, pin_level, hw_reset_n, pin_o, pin_oe;
  logic link_ind, speed_ind, act_ind, powerdown, internal_reset, seen;
  logic [7:0] rst_cycles = 8'h00;
  int bad_count = 0, tests_run = 0;
  always #10 clock = ~clock;
  pld_top #(.TICK_CYCLES(4)) i_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_good(link_good), .speed_100(speed_100),
    .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
    .irq_cond(irq_cond), .strap_pins(strap_pins), .hw_reset_n(hw_reset_n),
    .test_reset_n(test_reset_n), .powerdown_or_irq_pin_i(pin_level),
    .powerdown_or_irq_pin_o(pin_o), .powerdown_or_irq_pin_oe(pin_oe),
    .link_indicator(link_ind), .speed_indicator(speed_ind), .activity_indicator(act_ind),
    .powerdown(powerdown), .internal_reset(internal_reset));
  pld_far_model i_far (.clock(clock), .pin_oe(pin_oe), .pin_o(pin_o), .pull_low(pull_low),
    .rst_go(rst_go), .rst_cycles(rst_cycles), .pin_level(pin_level), .hw_reset_n(hw_reset_n));

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cyc

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] adr, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, adr, v, d);
  endtask : wr

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0, d);
    chk(d & m, exp);
  endtask : rd_chk

  // looks for a level on the link (sel 0) or the internal reset (sel 1)
  task automatic watch(input int n, input logic lvl, input bit sel);
    seen = 1'b0;
    repeat (n) begin
      @(negedge clock);
      if ((sel ? internal_reset : link_ind) === lvl) seen = 1'b1;
    end
  endtask : watch

  task automatic t_reset_values();
    rd_chk(CTRL_OFS, 32'h01, 32'h1f);
    rd_chk(STATUS_OFS, 32'h600, 32'hf00);
    rd_chk(4'h8, 32'h0, 32'hffffffff);
    wr(STATUS_OFS, 32'h1f);
    rd_chk(CTRL_OFS, 32'h01, 32'h1f);
    chk(pin_oe, 1'b0);
  endtask : t_reset_values

  task automatic t_link_speed();
    @(posedge clock);
    link_good <= 1'b1;
    speed_100 <= 1'b1;
    wait_cyc(3);
    chk(link_ind, 1'b1);
    chk(speed_ind, 1'b1);
    wr(CTRL_OFS, 32'h00);
    wait_cyc(3);
    chk(link_ind, 1'b1);
    @(posedge clock);
    link_good <= 1'b0;
    speed_100 <= 1'b0;
    wait_cyc(3);
    chk(link_ind, 1'b0);
    chk(speed_ind, 1'b0);
    wr(CTRL_OFS, 32'h01);
  endtask : t_link_speed

  // a single-cycle pulse must still be visible 100 cycles later, within the 50-tick stretch time
  task automatic t_activity();
    for (int i = 0; i < 2; i++) begin
      chk(act_ind, 1'b0);
      @(posedge clock);
      tx_active <= (i == 0);
      rx_active <= (i == 1);
      @(posedge clock);
      tx_active <= 1'b0;
      rx_active <= 1'b0;
      wait_cyc(100);
      chk(act_ind, 1'b1);
      wait_cyc(200);
    end
  endtask : t_activity

  task automatic t_duplex();
    wr(CTRL_OFS, 32'h03);
    @(posedge clock);
    full_duplex <= 1'b1;
    wait_cyc(3);
    chk(act_ind, 1'b0);
    wr(CTRL_OFS, 32'h07);
    wait_cyc(3);
    chk(act_ind, 1'b1);
    @(posedge clock);
    full_duplex <= 1'b0;
    wait_cyc(3);
    chk(act_ind, 1'b0);
  endtask : t_duplex

  task automatic t_blink();
    for (int m = 2; m < 4; m++) begin
      wr(CTRL_OFS, m);
      link_good <= 1'b1;
      wait_cyc(3);
      chk(link_ind, 1'b1);
      @(posedge clock);
      rx_active <= 1'b1;
      watch(500, 1'b0, 1'b0);
      chk(seen, 1'b1);
      watch(300, 1'b1, 1'b0);
      chk(seen, 1'b1);
      @(posedge clock);
      rx_active <= 1'b0;
      wait_cyc(300);
      chk(link_ind, 1'b1);
      @(posedge clock);
      link_good <= 1'b0;
    end
  endtask : t_blink

  task automatic t_pin();
    wr(CTRL_OFS, 32'h01);
    irq_cond <= 1'b1;
    wait_cyc(3);
    chk(pin_oe, 1'b0);
    @(posedge clock);
    irq_cond <= 1'b0;
    pull_low <= 1'b1;
    wait_cyc(8);
    chk(powerdown, 1'b1);
    @(posedge clock);
    pull_low <= 1'b0;
    wait_cyc(8);
    chk(powerdown, 1'b0);
    wr(CTRL_OFS, 32'h09);
    irq_cond <= 1'b1;
    wait_cyc(2);
    chk(pin_level, 1'b0);
    wait_cyc(8);
    chk(powerdown, 1'b0);
    @(posedge clock);
    irq_cond <= 1'b0;
    wait_cyc(2);
    chk({pin_oe, pin_level}, 2'b01);
  endtask : t_pin

  // short low ignored, long low resets and reloads straps
  task automatic t_hw_reset();
    @(posedge clock);
    strap_pins <= 4'h1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      rst_cycles <= (i == 0) ? 8'd20 : 8'd70;
      rst_go <= 1'b1;
      @(posedge clock);
      rst_go <= 1'b0;
      watch(100, 1'b1, 1'b1);
      chk(seen, i);
    end
    wait_cyc(10);
    rd_chk(CTRL_OFS, 32'h03, 32'h1f);
    rd_chk(STATUS_OFS, 32'h100, 32'hf00);
  endtask : t_hw_reset

  // the clear must act before the next rising edge, so only an asynchronous one passes
  task automatic t_test_reset();
    wr(CTRL_OFS, 32'h13);
    rd_chk(STATUS_OFS, 32'h20, 32'h20);
    @(posedge clock);
    test_reset_n <= 1'b0;
    @(negedge clock);
    chk(i_dut.test_mode_q, 1'b0);
    @(posedge clock);
    test_reset_n <= 1'b1;
    rd_chk(STATUS_OFS, 32'h0, 32'h20);
  endtask : t_test_reset

  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    wait_cyc(4);
    t_reset_values();
    t_link_speed();
    t_activity();
    t_duplex();
    t_blink();
    t_pin();
    t_hw_reset();
    t_test_reset();
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule : phy_led_reset_powerdown_pins_tb
